/* hdl/line_interface_ctrl.sv */
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Operation
// - Decode receive termination field, bits zero-two
// - Decode transmit termination field, same encoding
// - Report receive level continuously, 2.5 dB steps
// - Status bit one shows transmit open circuit
// - Current limit bit regardless of limiter enable
// - Jitter store near limit sets event
// - Reading status clears jitter limit event
// - Masked condition edges raise interrupt both ways
// - Masked jitter limit event raises interrupt
// - Remote loop sends line receive to transmit, except in sync mode
// - Local loop substitutes transmit data for receive
// - Sync mode outputs the line receive positive rail as receive clock
// - Sync mode leaves frame sync undriven
// - Sync mode transmits square wave
// - Jitter clock select applies in T1 only
// - Remote loop drives recovered clock on transmit
module line_interface_ctrl
  import line_if_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic line_rx_pos, // Line receive, positive rail
  input wire logic line_rx_neg, // Line receive, negative rail
  input wire logic rx_clock_rec, // Recovered receive clock
  input wire logic tx_fmt_pos, // Formatter transmit data, positive
  input wire logic tx_fmt_neg, // Formatter transmit data, negative
  input wire logic tx_clock_in, // Normal transmit clock
  input wire logic pll_6312_clk, // 6312 kHz square wave from PLL
  input wire logic [3:0] rx_level_in, // Level code from receive slicer
  input wire logic tx_open_det, // Open-circuit detector
  input wire logic tx_limit_det, // Current limiter would activate
  input wire logic jitter_near_limit, // Elastic store within limit margin
  input wire logic rx_frame_sync_in, // Frame sync from receive framer
  output logic [3:0] rx_term_en, // Receive termination enables
  output logic [3:0] tx_term_en, // Transmit termination enables
  output logic [1:0] mclk_prescale, // Master clock prescaler
  output logic jitter_clk_src_sel, // Jitter clock: 0 prescaled, 1 PLL
  output logic line_tx_pos, // Line driver data, positive
  output logic line_tx_neg, // Line driver data, negative
  output logic tx_clock_out, // Transmit clock output
  output logic rx_data_pos, // Data to receive processing, positive
  output logic rx_data_neg, // Data to receive processing, negative
  output logic rx_clock_out, // Receive clock output
  output logic rx_frame_sync_out, // Frame sync pin, output value
  output logic rx_frame_sync_oe, // Frame sync pin, output enable
  output logic irq // Interrupt, active high
);

  logic [14:0] pins_s;
  logic rx_pos_s, rx_neg_s, rx_clk_s, fmt_pos_s, fmt_neg_s, tx_clk_s, pll_s;
  logic [3:0] level_s;
  logic open_s, limit_s, jlim_s, fsync_s;

  bit_sync #(.W(15)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({line_rx_pos, line_rx_neg, rx_clock_rec, tx_fmt_pos, tx_fmt_neg, tx_clock_in, pll_6312_clk,
               rx_level_in, tx_open_det, tx_limit_det, jitter_near_limit, rx_frame_sync_in}),
    .sync_out(pins_s)
  );
  assign {rx_pos_s, rx_neg_s, rx_clk_s, fmt_pos_s, fmt_neg_s, tx_clk_s, pll_s,
          level_s, open_s, limit_s, jlim_s, fsync_s} = pins_s;

  // Software registers
  logic [7:0] term_prescale_q, irq_mask_q, loopback_q, line_ctrl_two_q, mode_q;
  logic remote_loop_en, local_loop_en, e1_mode, sync_mode;
  assign remote_loop_en = loopback_q[REMOTE_LOOP_BIT];
  assign local_loop_en = loopback_q[LOCAL_LOOP_BIT];
  assign e1_mode = mode_q[MODE_E1_BIT];
  assign sync_mode = mode_q[MODE_SYNC6312_BIT];

  // Write channel
  logic aw_have_q, w_have_q, aw_have_d, w_have_d, bvalid_d, awready_q, wready_q, bvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic w_strb0_q;
  logic [1:0] bresp_q;
  logic aw_take, w_take, do_write;
  reg_sel_t wsel;

  assign aw_take = awvalid & awready_q;
  assign w_take = wvalid & wready_q;
  assign do_write = aw_have_q & w_have_q & ~bvalid_q;
  assign wsel = decode_addr(aw_addr_q);

  always_comb begin
    aw_have_d = (aw_have_q | aw_take) & ~do_write;
    w_have_d = (w_have_q | w_take) & ~do_write;
    bvalid_d = do_write | (bvalid_q & ~bready);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb0_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= ~aw_have_d & ~bvalid_d;
      wready_q <= ~w_have_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      if (aw_take) begin
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        w_data_q <= wdata;
        w_strb0_q <= wstrb[0];
      end
      if (do_write) begin
        bresp_q <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // Only the low byte lane carries register data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      term_prescale_q <= TERM_PRESCALE_RST;
      irq_mask_q <= IRQ_MASK_RST;
      loopback_q <= LOOPBACK_RST;
      line_ctrl_two_q <= LINE_CTRL_TWO_RST;
      mode_q <= MODE_RST;
    end else if (do_write && w_strb0_q) begin
      unique case (wsel)
        SEL_TERM_PRESCALE: term_prescale_q <= w_data_q[7:0];
        SEL_IRQ_MASK: irq_mask_q <= w_data_q[7:0];
        SEL_LOOPBACK: loopback_q <= w_data_q[7:0];
        SEL_LINE_CTRL_TWO: line_ctrl_two_q <= w_data_q[7:0];
        SEL_MODE: mode_q <= w_data_q[7:0];
        default: ;
      endcase
    end
  end

  // Read channel
  logic ar_take, rvalid_d, arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] rd_byte, status_val;
  reg_sel_t rsel;
  logic status_read;

  assign ar_take = arvalid & arready_q;
  assign rsel = decode_addr(araddr);
  assign status_read = ar_take & (rsel == SEL_STATUS);
  assign rvalid_d = ar_take | (rvalid_q & ~rready);

  // Status events
  logic open_prev_q, limit_prev_q, jlim_prev_q;
  logic jit_event_q, open_pend_q, limit_pend_q, jit_event_set;
  assign jit_event_set = jlim_s & ~jlim_prev_q;

  always_comb begin
    status_val = 8'h00;
    status_val[OPEN_CIRCUIT_BIT] = open_s;
    status_val[CURRENT_LIMIT_BIT] = limit_s;
    status_val[JITTER_LIMIT_BIT] = jit_event_q;
  end

  always_comb begin
    unique case (rsel)
      SEL_RX_LEVEL: rd_byte = {4'h0, level_s};
      SEL_STATUS: rd_byte = status_val;
      SEL_IRQ_MASK: rd_byte = irq_mask_q;
      SEL_LOOPBACK: rd_byte = loopback_q;
      SEL_LINE_CTRL_TWO: rd_byte = line_ctrl_two_q;
      SEL_TERM_PRESCALE: rd_byte = term_prescale_q;
      SEL_MODE: rd_byte = mode_q;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= {24'h000000, rd_byte};
        rresp_q <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // Event and pending flags; a new event wins over a read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_prev_q <= 1'b0;
      limit_prev_q <= 1'b0;
      jlim_prev_q <= 1'b0;
      jit_event_q <= 1'b0;
      open_pend_q <= 1'b0;
      limit_pend_q <= 1'b0;
    end else begin
      open_prev_q <= open_s;
      limit_prev_q <= limit_s;
      jlim_prev_q <= jlim_s;
      jit_event_q <= jit_event_set | (jit_event_q & ~status_read);
      open_pend_q <= (open_s ^ open_prev_q) | (open_pend_q & ~status_read);
      limit_pend_q <= (limit_s ^ limit_prev_q) | (limit_pend_q & ~status_read);
    end
  end

  logic irq_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (open_pend_q & irq_mask_q[OPEN_CIRCUIT_BIT])
             | (limit_pend_q & irq_mask_q[CURRENT_LIMIT_BIT])
             | (jit_event_q & irq_mask_q[JITTER_LIMIT_BIT]);
    end
  end

  // Termination and clocking outputs
  logic [3:0] rx_term_d, tx_term_d, rx_term_q, tx_term_q;
  logic [1:0] prescale_q;
  logic jclk_sel_q;

  term_decoder u_rx_term (
    .code(term_prescale_q[RX_TERM_LSB +: 3]),
    .enable(rx_term_d)
  );
  term_decoder u_tx_term (
    .code(term_prescale_q[TX_TERM_LSB +: 3]),
    .enable(tx_term_d)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_term_q <= 4'h0;
      tx_term_q <= 4'h0;
      prescale_q <= 2'h0;
      jclk_sel_q <= 1'b0;
    end else begin
      rx_term_q <= rx_term_d;
      tx_term_q <= tx_term_d;
      prescale_q <= term_prescale_q[PRESCALE_LSB +: 2];
      jclk_sel_q <= line_ctrl_two_q[JITTER_CLK_SEL_BIT] & ~e1_mode;
    end
  end

  // Data paths, loopbacks and 6312 kHz mode
  logic tx_pos_q, tx_neg_q, tx_clk_out_q, rx_pos_q, rx_neg_q, rx_clk_out_q, fs_q, fs_oe_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pos_q <= 1'b0;
      tx_neg_q <= 1'b0;
      tx_clk_out_q <= 1'b0;
      rx_pos_q <= 1'b0;
      rx_neg_q <= 1'b0;
      rx_clk_out_q <= 1'b0;
      fs_q <= 1'b0;
      fs_oe_q <= 1'b0;
    end else begin
      if (sync_mode) begin
        tx_pos_q <= pll_s;
        tx_neg_q <= ~pll_s;
      end else if (remote_loop_en) begin
        tx_pos_q <= rx_pos_s;
        tx_neg_q <= rx_neg_s;
      end else begin
        tx_pos_q <= fmt_pos_s;
        tx_neg_q <= fmt_neg_s;
      end
      if (remote_loop_en) begin
        tx_clk_out_q <= rx_clk_s;
      end else begin
        tx_clk_out_q <= sync_mode ? pll_s : tx_clk_s;
      end
      // Looped data feeds the receive path ahead of the jitter attenuator
      rx_pos_q <= local_loop_en ? fmt_pos_s : rx_pos_s;
      rx_neg_q <= local_loop_en ? fmt_neg_s : rx_neg_s;
      rx_clk_out_q <= sync_mode ? rx_pos_s : rx_clk_s;
      fs_q <= fsync_s;
      fs_oe_q <= ~sync_mode;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign rx_term_en = rx_term_q;
  assign tx_term_en = tx_term_q;
  assign mclk_prescale = prescale_q;
  assign jitter_clk_src_sel = jclk_sel_q;
  assign line_tx_pos = tx_pos_q;
  assign line_tx_neg = tx_neg_q;
  assign tx_clock_out = tx_clk_out_q;
  assign rx_data_pos = rx_pos_q;
  assign rx_data_neg = rx_neg_q;
  assign rx_clock_out = rx_clk_out_q;
  assign rx_frame_sync_out = fs_q;
  assign rx_frame_sync_oe = fs_oe_q;
  assign irq = irq_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_rx_term_75: assert property ((term_prescale_q[2:0] == TERM_75) |=> (rx_term_q == 4'h1))
    else $error("rx termination 75 ohm not selected");
  a_tx_term_off: assert property ((term_prescale_q[5:3] > TERM_110) |=> (tx_term_q == 4'h0))
    else $error("tx termination not disabled for high code");
  a_jit_event_sets: assert property (jit_event_set |=> jit_event_q)
    else $error("jitter limit event not captured");
  a_jit_event_clear: assert property ((status_read && !jit_event_set) |=> !jit_event_q)
    else $error("jitter limit event not cleared by read");
  a_open_edge_irq: assert property ((open_s != open_prev_q) && irq_mask_q[OPEN_CIRCUIT_BIT]
    && !do_write |=> ##1 irq_q)
    else $error("open circuit edge gave no interrupt");
  a_irq_masked: assert property ((irq_mask_q == 8'h00) |=> !irq_q)
    else $error("interrupt raised with all sources masked");
  a_jit_event_irq: assert property (jit_event_q && irq_mask_q[JITTER_LIMIT_BIT] |=> irq_q)
    else $error("jitter limit interrupt missing");
  a_remote_loop: assert property (remote_loop_en && !sync_mode |=> (tx_pos_q == $past(rx_pos_s)))
    else $error("remote loop data not on transmit");
  a_local_loop: assert property (local_loop_en |=> (rx_pos_q == $past(fmt_pos_s)))
    else $error("local loop data not on receive");
  a_sync_fs_off: assert property (sync_mode |=> !fs_oe_q)
    else $error("frame sync driven in sync mode");
  a_remote_clk: assert property (remote_loop_en |=> (tx_clk_out_q == $past(rx_clk_s)))
    else $error("transmit clock not recovered clock");
  a_write_resp: assert property (do_write |=> bvalid_q)
    else $error("write response missing");

  c_write: cover property (do_write && wsel == SEL_LOOPBACK);
  c_status_read: cover property (status_read && jit_event_q);
  c_irq_rise: cover property (!irq_q ##1 irq_q);

endmodule : line_interface_ctrl

/* hdl/line_if_pkg.sv */
package line_if_pkg;

  localparam int ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_RX_LEVEL = 10'h011;
  localparam logic [9:0] IDX_STATUS = 10'h014;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h015;
  localparam logic [9:0] IDX_LOOPBACK = 10'h020;
  localparam logic [9:0] IDX_LINE_CTRL_TWO = 10'h031;
  localparam logic [9:0] IDX_TERM_PRESCALE = 10'h033;
  localparam logic [9:0] IDX_MODE = 10'h040;

  // Field positions
  localparam int RX_TERM_LSB = 0;
  localparam int TX_TERM_LSB = 3;
  localparam int PRESCALE_LSB = 6;
  localparam int JITTER_CLK_SEL_BIT = 3;
  localparam int OPEN_CIRCUIT_BIT = 1;
  localparam int CURRENT_LIMIT_BIT = 2;
  localparam int JITTER_LIMIT_BIT = 4;
  localparam int REMOTE_LOOP_BIT = 2;
  localparam int LOCAL_LOOP_BIT = 3;
  localparam int MODE_E1_BIT = 0;
  localparam int MODE_SYNC6312_BIT = 1;

  // Reset values
  localparam logic [7:0] TERM_PRESCALE_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] LOOPBACK_RST = 8'h00;
  localparam logic [7:0] LINE_CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;

  // Termination codes
  localparam logic [2:0] TERM_75 = 3'h1;
  localparam logic [2:0] TERM_100 = 3'h2;
  localparam logic [2:0] TERM_120 = 3'h3;
  localparam logic [2:0] TERM_110 = 3'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_RX_LEVEL, SEL_STATUS, SEL_IRQ_MASK, SEL_LOOPBACK, SEL_LINE_CTRL_TWO, SEL_TERM_PRESCALE, SEL_MODE
  } reg_sel_t;

  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[ADDR_W-1:2])
        IDX_RX_LEVEL: sel = SEL_RX_LEVEL;
        IDX_STATUS: sel = SEL_STATUS;
        IDX_IRQ_MASK: sel = SEL_IRQ_MASK;
        IDX_LOOPBACK: sel = SEL_LOOPBACK;
        IDX_LINE_CTRL_TWO: sel = SEL_LINE_CTRL_TWO;
        IDX_TERM_PRESCALE: sel = SEL_TERM_PRESCALE;
        IDX_MODE: sel = SEL_MODE;
        default: sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction : decode_addr

endpackage : line_if_pkg

/* hdl/bit_sync.sv */
`timescale 1ns/1ns
module bit_sync #(
  parameter int W = 1
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [W-1:0] async_in, // Pins from outside the clock domain
  output logic [W-1:0] sync_out // Two-stage synchronised copy
);

  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : bit_sync

/* hdl/term_decoder.sv */
`timescale 1ns/1ns
module term_decoder
  import line_if_pkg::*;
(
  input wire logic [2:0] code, // Termination select field
  output logic [3:0] enable // One-hot: 75, 100, 120, 110 ohm
);

  always_comb begin
    enable = 4'h0;
    unique case (code)
      TERM_75: enable = 4'h1;
      TERM_100: enable = 4'h2;
      TERM_120: enable = 4'h4;
      TERM_110: enable = 4'h8;
      default: enable = 4'h0;
    endcase
  end

endmodule : term_decoder

/* bench/line_side_model.sv */
`timescale 1ns/1ns
module line_side_model (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Reset, active low
  input wire logic [7:0] rnd, // Random line pattern
  input wire logic [3:0] level, // Receive level to report
  input wire logic [2:0] det, // Jitter, limit, open conditions
  output logic line_rx_pos, // Receive rail, positive
  output logic line_rx_neg, // Receive rail, negative
  output logic rx_clock_rec, // Recovered clock
  output logic tx_fmt_pos, // Formatter data, positive
  output logic tx_fmt_neg, // Formatter data, negative
  output logic tx_clock_in, // Transmit clock
  output logic pll_6312_clk, // Sync clock
  output logic [3:0] rx_level_in, // Level code
  output logic tx_open_det, // Open circuit
  output logic tx_limit_det, // Limiter would act
  output logic jitter_near_limit, // Store near limit
  output logic rx_frame_sync_in // Frame sync
);
  logic [2:0] cnt_q;
  always_ff @(posedge aclk) begin
    cnt_q <= aresetn ? cnt_q + 3'h1 : 3'h0;
  end
  // Bipolar rails are never both high
  assign line_rx_pos = rnd[0];
  assign line_rx_neg = rnd[1] & ~rnd[0];
  assign tx_fmt_pos = rnd[2];
  assign tx_fmt_neg = rnd[3] & ~rnd[2];
  assign rx_frame_sync_in = rnd[4];
  assign tx_clock_in = cnt_q[0];
  assign rx_clock_rec = cnt_q[1];
  assign pll_6312_clk = cnt_q[2];
  assign rx_level_in = level;
  assign tx_open_det = det[0];
  assign tx_limit_det = det[1];
  assign jitter_near_limit = det[2];
endmodule : line_side_model

/* bench/line_interface_ctrl_test.sv */
`timescale 1ns/1ns
module line_interface_ctrl_test;
  import line_if_pkg::*;
  localparam logic [11:0] LV = {IDX_RX_LEVEL, 2'h0};
  localparam logic [11:0] ST = {IDX_STATUS, 2'h0};
  localparam logic [11:0] MK = {IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] LB = {IDX_LOOPBACK, 2'h0};
  localparam logic [11:0] L2 = {IDX_LINE_CTRL_TWO, 2'h0};
  localparam logic [11:0] TP = {IDX_TERM_PRESCALE, 2'h0};
  localparam logic [11:0] MD = {IDX_MODE, 2'h0};
  logic [11:0] adrs [7] = '{LV, ST, MK, LB, L2, TP, MD};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, mclk_prescale;
  logic line_rx_pos, line_rx_neg, rx_clock_rec, tx_fmt_pos, tx_fmt_neg, tx_clock_in, pll_6312_clk;
  logic [3:0] rx_level_in, rx_term_en, tx_term_en;
  logic tx_open_det, tx_limit_det, jitter_near_limit, rx_frame_sync_in, jitter_clk_src_sel;
  logic line_tx_pos, line_tx_neg, tx_clock_out, rx_data_pos, rx_data_neg, rx_clock_out;
  logic rx_frame_sync_out, rx_frame_sync_oe, irq;
  logic [7:0] rnd = 8'h00, v;
  logic [3:0] level = 4'h0;
  logic [2:0] det = 3'h0;
  int n_fail = 0, tests_run = 0, cycles = 0, seed = 32'hd55f, i;
  int mdl[int];

  always #5 aclk = ~aclk;

  line_interface_ctrl dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .line_rx_pos, .line_rx_neg, .rx_clock_rec, .tx_fmt_pos, .tx_fmt_neg, .tx_clock_in, .pll_6312_clk,
    .rx_level_in, .tx_open_det, .tx_limit_det, .jitter_near_limit, .rx_frame_sync_in, .rx_term_en,
    .tx_term_en, .mclk_prescale, .jitter_clk_src_sel, .line_tx_pos, .line_tx_neg, .tx_clock_out,
    .rx_data_pos, .rx_data_neg, .rx_clock_out, .rx_frame_sync_out, .rx_frame_sync_oe, .irq);

  line_side_model far_end (.aclk, .aresetn, .rnd, .level, .det, .line_rx_pos, .line_rx_neg, .rx_clock_rec,
    .tx_fmt_pos, .tx_fmt_neg, .tx_clock_in, .pll_6312_clk, .rx_level_in, .tx_open_det, .tx_limit_det,
    .jitter_near_limit, .rx_frame_sync_in);

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w;
    int t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    for (t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) break;
    end
    check("bvalid", 32'(bvalid), 32'h1);
    check("bresp", 32'(bresp), 32'(er));
    bready <= 1'b0;
    if (er == RESP_OKAY && wstrb[0]) mdl[a] = d;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    logic ar;
    int t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar = 1'b0;
    for (t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (!ar && arready) begin
        ar = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) break;
    end
    check("rvalid", 32'(rvalid), 32'h1);
    check("rdata", rdata, {24'h0, e});
    check("rresp", 32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask : rd

  // Condition levels a for three cycles, then b, then settle
  task automatic drive_det(input logic [2:0] a, input logic [2:0] b);
    @(posedge aclk);
    det <= a;
    repeat (3) @(posedge aclk);
    det <= b;
    repeat (6) @(posedge aclk);
    #1;
  endtask : drive_det

  function automatic logic [3:0] term(input logic [2:0] c);
    return (c >= 3'h1 && c <= 3'h4) ? 4'(1 << (c - 3'h1)) : 4'h0;
  endfunction : term

  // Pins seen three edges earlier decide the line outputs
  task automatic link(input logic [7:0] lb, input logic [7:0] md);
    logic [7:0] q[$];
    logic [7:0] p, e, s;
    logic rl, ll, sy;
    int k;
    wr(LB, lb, RESP_OKAY);
    wr(MD, md, RESP_OKAY);
    rl = lb[2];
    ll = lb[3];
    sy = md[1];
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      rnd <= 8'($random(seed));
      #1;
      q.push_back({pll_6312_clk, rx_clock_rec, tx_clock_in, tx_fmt_neg, tx_fmt_pos, line_rx_neg, line_rx_pos,
        rx_frame_sync_in});
      if (k > 5) begin
        p = q[k-3];
        e = {sy ? p[7] : rl ? p[1] : p[3], sy ? ~p[7] : rl ? p[2] : p[4], rl ? p[6] : sy ? p[7] : p[5],
          ll ? p[3] : p[1], ll ? p[4] : p[2], sy ? p[1] : p[6], sy ? 1'b0 : p[0], ~sy};
        s = {line_tx_pos, line_tx_neg, tx_clock_out, rx_data_pos, rx_data_neg, rx_clock_out,
          rx_frame_sync_out & rx_frame_sync_oe, rx_frame_sync_oe};
        check("line outputs", 32'(s), 32'(e));
      end
    end
  endtask : link

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (adrs[j]) begin
      mdl[adrs[j]] = 0;
      rd(adrs[j], 8'h00, RESP_OKAY);
    end
    for (i = 4; i < 7; i++) begin
      wr(adrs[i], 8'($random(seed)), RESP_OKAY);
      rd(adrs[i], 8'(mdl[adrs[i]]), RESP_OKAY);
      wr(adrs[i], 8'h00, RESP_OKAY);
    end
    wr(MK, 8'h16, RESP_OKAY);
    rd(MK, 8'(mdl[MK]), RESP_OKAY);
    wr(LB, 8'h0C, RESP_OKAY);
    rd(LB, 8'(mdl[LB]), RESP_OKAY);
    wr(LB, 8'h00, RESP_OKAY);
    wr(12'h3FC, 8'hFF, RESP_SLVERR);
    rd(12'h3FC, 8'h00, RESP_SLVERR);
    wr(MK + 12'h1, 8'h02, RESP_SLVERR);
    rd(MK, 8'(mdl[MK]), RESP_OKAY);
    // Low byte lane off: the write must leave the register alone
    wstrb <= 4'hE;
    wr(MK, 8'h00, RESP_OKAY);
    wstrb <= 4'hF;
    rd(MK, 8'(mdl[MK]), RESP_OKAY);
    for (i = 0; i < 8; i++) begin
      wr(TP, {i[1:0], i[2:0], 3'(7 - i)}, RESP_OKAY);
      repeat (3) @(posedge aclk);
      #1;
      check("rx_term_en", 32'(rx_term_en), 32'(term(3'(7 - i))));
      check("tx_term_en", 32'(tx_term_en), 32'(term(i[2:0])));
      check("mclk_prescale", 32'(mclk_prescale), 32'(i & 3));
    end
    for (i = 0; i < 4; i++) begin
      wr(MD, 8'(i & 1), RESP_OKAY);
      wr(L2, 8'((i & 2) << 2), RESP_OKAY);
      repeat (3) @(posedge aclk);
      #1;
      check("jitter_clk_src_sel", 32'(jitter_clk_src_sel), 32'(i[1] & ~i[0]));
    end
    wr(MD, 8'h00, RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : (i == 3) ? 8'h0F : 8'($random(seed) & 15);
      @(posedge aclk);
      level <= v[3:0];
      repeat (4) @(posedge aclk);
      rd(LV, v, RESP_OKAY);
    end
    wr(MK, 8'h00, RESP_OKAY);
    drive_det(3'b011, 3'b011);
    check("irq", 32'(irq), 32'h0);
    rd(ST, 8'h06, RESP_OKAY);
    wr(MK, 8'h02, RESP_OKAY);
    drive_det(3'b010, 3'b010);
    check("irq", 32'(irq), 32'h1);
    rd(ST, 8'h04, RESP_OKAY);
    repeat (2) @(posedge aclk);
    #1;
    check("irq", 32'(irq), 32'h0);
    drive_det(3'b011, 3'b011);
    check("irq", 32'(irq), 32'h1);
    rd(ST, 8'h06, RESP_OKAY);
    wr(MK, 8'h04, RESP_OKAY);
    drive_det(3'b001, 3'b001);
    check("irq", 32'(irq), 32'h1);
    rd(ST, 8'h02, RESP_OKAY);
    wr(MK, 8'h10, RESP_OKAY);
    check("irq", 32'(irq), 32'h0);
    drive_det(3'b101, 3'b001);
    check("irq", 32'(irq), 32'h1);
    rd(ST, 8'h12, RESP_OKAY);
    rd(ST, 8'h02, RESP_OKAY);
    check("irq", 32'(irq), 32'h0);
    wr(MK, 8'h00, RESP_OKAY);
    drive_det(3'b101, 3'b001);
    check("irq", 32'(irq), 32'h0);
    rd(ST, 8'h12, RESP_OKAY);
    link(8'h00, 8'h00);
    link(8'h04, 8'h00);
    link(8'h08, 8'h00);
    link(8'h00, 8'h02);
    link(8'h04, 8'h02);
    final_report();
  end
endmodule : line_interface_ctrl_test
